// ### src/frame_codec_map.svh
// Purpose: byte values, error codes and reset values of the serial frame codec
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only
`ifndef FRAME_CODEC_MAP_SVH
`define FRAME_CODEC_MAP_SVH

// ============================================================
// line byte values
`define START_BYTE 8'h7E
`define ESC_BYTE 8'h7D
`define ESC_XOR 8'h20
`define XON_BYTE 8'h11
`define XOFF_BYTE 8'h13
`define CSUM_GOOD 8'hFF

// ============================================================
// failure codes carried in a status frame
`define ERR_CHECKSUM 8'h01
`define ERR_LENGTH 8'h02

// ============================================================
// status frame shape and reset values
`define STATUS_LEN 16'h0002
`define ZERO_BYTE 8'h00
`define ZERO_LEN 16'h0000

`endif

// ### src/frame_codec_pkg.sv
// Purpose: shared types of the serial frame codec
// Assumes: nothing
// Notes: state encodings are written out in binary
package frame_codec_pkg;

	// ============================================================
	// operating mode selected by api_mode_select
	typedef enum logic [1:0] {
		MODE_TRANSPARENT = 2'b00,
		MODE_API = 2'b01,
		MODE_API_ESC = 2'b10,
		MODE_UNUSED = 2'b11
	} api_mode_type;

	// ============================================================
	// receive parser states
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_LEN_HI = 3'b001,
		RX_LEN_LO = 3'b010,
		RX_DATA = 3'b011,
		RX_CSUM = 3'b100,
		RX_RELEASE = 3'b101
	} rx_state_type;

	// ============================================================
	// transmit builder states
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_LEN_HI = 3'b010,
		TX_LEN_LO = 3'b011,
		TX_DATA = 3'b100,
		TX_CSUM = 3'b101
	} tx_state_type;

endpackage : frame_codec_pkg

// ### src/byte_stream_if.sv
// Purpose: valid/ready byte stream between the codec's own modules
// Assumes: one clock, transfer when valid and ready are both high
// Notes: src drives data and valid, snk drives ready
interface byte_stream_if;
	logic valid; // byte offered
	logic ready; // byte accepted
	logic [7:0] data; // byte value
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ### src/escape_encoder.sv
// Purpose: inserts escape sequences into the outgoing byte stream
// Assumes: upstream holds a byte stable until it is taken
// Notes: an escaped byte takes two downstream transfers
`include "frame_codec_map.svh"
module escape_encoder (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_esc_on,
	input wire logic i_raw,
	byte_stream_if.snk up,
	byte_stream_if.src dn
);
	import frame_codec_pkg::*;

	logic second_reg; // escape byte sent, modified byte next
	logic special; // byte is one of the four reserved values
	logic wants; // this byte must go out escaped

	// ============================================================
	// escape decision
	always_comb begin
		special = (up.data == `START_BYTE) || (up.data == `ESC_BYTE) ||
			(up.data == `XON_BYTE) || (up.data == `XOFF_BYTE);
		wants = up.valid && i_esc_on && !i_raw && special;
	end

	// escape byte first, then the byte flipped by the xor value
	assign dn.valid = up.valid;
	assign dn.data = second_reg ? (up.data ^ `ESC_XOR) : (wants ? `ESC_BYTE : up.data);
	assign up.ready = dn.ready && (!wants || second_reg);

	// ============================================================
	// phase of an escaped byte
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			second_reg <= 1'b0;
		end else if (i_ce && wants && dn.ready) begin
			second_reg <= !second_reg;
		end
	end
endmodule // escape_encoder

// ### src/byte_fifo2.sv
// Purpose: small buffer between the encoder and the host serial output
// Assumes: DEPTH is a power of two
// Notes: ready drops when full so the encoder stalls and no byte is lost
module byte_fifo2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	byte_stream_if.snk wr,
	byte_stream_if.src rd
);
	import frame_codec_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH]; // stored entries
	logic [AW-1:0] wr_ptr_reg; // next write slot
	logic [AW-1:0] rd_ptr_reg; // oldest entry
	logic [AW:0] count_reg; // entries held
	logic push; // write this cycle
	logic pop; // read this cycle

	assign wr.ready = (count_reg != DEPTH[AW:0]);
	assign rd.valid = (count_reg != '0);
	assign rd.data = mem[rd_ptr_reg];
	assign push = i_ce && wr.valid && wr.ready;
	assign pop = i_ce && rd.valid && rd.ready;

	// ============================================================
	// storage, no reset needed
	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= wr.data;
		end
	end

	// ============================================================
	// pointers and fill level
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // byte_fifo2

// ### src/serial_api_frame_codec.sv
// Purpose: frames and deframes host serial packets in transparent or api modes
// Assumes: all inputs synchronous to i_mclk; i_ce low freezes every flip-flop
// Notes: received frames are held whole and released only after a good checksum
`include "frame_codec_map.svh"

// Overview of operation
// - mode setting: 0 transparent, 1 framed, 2 escaped
// - transparent mode passes bytes through untouched
// - frame: start byte, length msb first, data, checksum
// - bytes before a start byte silently dropped
// - bad frame answered with a status frame
// - escaped mode: bare start byte restarts frame
// - escape is 0x7D then byte xor 0x20
// - escape exactly 0x7E, 0x7D, 0x11, 0x13
// - escape length, data, checksum, never start byte
// - length counts data bytes before escaping
// - checksum over unescaped byte values
// - length equals number of frame data bytes
// - first data byte is the frame type
// - multi-byte fields sent most significant first
// - checksum is 0xFF minus low sum byte
// - accept when data sum plus checksum is 0xFF
// - bad checksum frame is never acted on
// - escaped mode only when host link is uart
// - escaping applies in both directions
module serial_api_frame_codec #(
	parameter int FRAME_DEPTH = 256,
	parameter logic [7:0] STATUS_TYPE = 8'hF0 // arbitrary status frame type code
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire frame_codec_pkg::api_mode_type i_api_mode_select,
	input wire logic i_host_is_uart,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_ready,
	output logic o_rf_valid,
	output logic [7:0] o_rf_data,
	output logic o_rf_last,
	input wire logic i_rf_ready,
	input wire logic i_out_valid,
	input wire logic [7:0] i_out_data,
	input wire logic [15:0] i_out_len,
	output logic o_out_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready
);
	import frame_codec_pkg::*;

	// ============================================================
	// declarations
	api_mode_type mode; // effective operating mode
	logic framed; // either api mode
	logic esc_on; // escaped api mode in force
	rx_state_type rx_state_reg; // parser state
	logic esc_pend_reg; // escape byte seen, next byte is flipped
	logic [7:0] len_hi_reg; // length high byte
	logic [15:0] rx_len_reg; // received frame length
	logic [15:0] wr_idx_reg; // next store slot
	logic [15:0] rd_idx_reg; // next release slot
	logic [7:0] rx_sum_reg; // running data sum
	logic [7:0] frame_mem [FRAME_DEPTH]; // held frame data
	logic rx_take; // input byte accepted
	logic byte_ev; // decoded byte available
	logic restart; // bare start byte in escaped mode
	logic [7:0] value; // unescaped byte
	logic [15:0] len_full; // assembled length
	logic rx_err; // failure pulse to builder
	logic [7:0] rx_err_code; // its failure kind
	logic rf_load; // output stage may take a byte
	logic rf_valid_reg; // output stage holds a byte
	logic [7:0] rf_data_reg; // output stage byte
	logic rf_last_reg; // output stage closes a frame
	tx_state_type tx_state_reg; // builder state
	logic err_pend_reg; // status frame owed to host
	logic [7:0] err_code_reg; // kind of the owed failure
	logic [7:0] err_hold_reg; // kind being sent now
	logic from_status_reg; // current frame is a status frame
	logic [15:0] tx_len_reg; // current frame length
	logic [15:0] tx_cnt_reg; // data bytes sent
	logic [7:0] tx_sum_reg; // sum of sent data bytes
	logic [7:0] tx_byte; // byte offered to encoder
	logic tx_step; // encoder took a byte
	logic enc_raw; // byte must not be escaped
	logic picking; // builder starts a status frame now

	byte_stream_if enc_up ();
	byte_stream_if enc_dn ();
	byte_stream_if fifo_out ();

	// ============================================================
	// mode decode
	always_comb begin
		case (i_api_mode_select)
			MODE_TRANSPARENT: mode = MODE_TRANSPARENT;
			MODE_API: mode = MODE_API;
			MODE_API_ESC: mode = i_host_is_uart ? MODE_API_ESC : MODE_API;
			default: mode = MODE_TRANSPARENT;
		endcase
		framed = (mode != MODE_TRANSPARENT);
		esc_on = (mode == MODE_API_ESC);
	end

	// ============================================================
	// receive side decode
	assign rf_load = !rf_valid_reg || i_rf_ready;
	assign o_rx_ready = framed ? (rx_state_reg != RX_RELEASE) : rf_load;
	assign rx_take = i_ce && i_rx_valid && o_rx_ready;
	assign restart = rx_take && esc_on && !esc_pend_reg && (i_rx_data == `START_BYTE);
	assign byte_ev = rx_take && framed &&
		!(esc_on && !esc_pend_reg && (i_rx_data == `ESC_BYTE));
	assign value = esc_pend_reg ? (i_rx_data ^ `ESC_XOR) : i_rx_data;
	assign len_full = {len_hi_reg, value};

	// escape flag tracks the line, never the data
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			esc_pend_reg <= 1'b0;
		end else if (rx_take) begin
			esc_pend_reg <= esc_on && !esc_pend_reg && (i_rx_data == `ESC_BYTE);
		end
	end

	// ============================================================
	// receive parser
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rx_state_reg <= RX_IDLE;
			len_hi_reg <= `ZERO_BYTE;
			rx_len_reg <= `ZERO_LEN;
			wr_idx_reg <= `ZERO_LEN;
			rx_sum_reg <= `ZERO_BYTE;
		end else if (i_ce) begin
			if (restart) begin
				rx_state_reg <= RX_LEN_HI;
			end else if (byte_ev) begin
				case (rx_state_reg)
					RX_IDLE: begin
						if (i_rx_data == `START_BYTE) begin
							rx_state_reg <= RX_LEN_HI;
						end // other bytes fall away here
					end
					RX_LEN_HI: begin
						len_hi_reg <= value;
						rx_state_reg <= RX_LEN_LO;
					end
					RX_LEN_LO: begin
						rx_len_reg <= len_full;
						wr_idx_reg <= `ZERO_LEN;
						rx_sum_reg <= `ZERO_BYTE;
						if (len_full == `ZERO_LEN || len_full > 16'(FRAME_DEPTH)) begin
							rx_state_reg <= RX_IDLE;
						end else begin
							rx_state_reg <= RX_DATA;
						end
					end
					RX_DATA: begin
						rx_sum_reg <= rx_sum_reg + value;
						wr_idx_reg <= wr_idx_reg + 16'h0001;
						if (wr_idx_reg == rx_len_reg - 16'h0001) begin
							rx_state_reg <= RX_CSUM;
						end
					end
					RX_CSUM: begin
						if (8'(rx_sum_reg + value) == `CSUM_GOOD) begin
							rx_state_reg <= RX_RELEASE;
						end else begin
							rx_state_reg <= RX_IDLE;
						end
					end
					default: rx_state_reg <= RX_IDLE;
				endcase
			end else if (rx_state_reg == RX_RELEASE && rf_load &&
				rd_idx_reg == rx_len_reg - 16'h0001) begin
				rx_state_reg <= RX_IDLE;
			end
		end
	end

	// frame store, data only, type byte first
	always_ff @(posedge i_mclk) begin
		if (i_ce && byte_ev && !restart && rx_state_reg == RX_DATA) begin
			frame_mem[wr_idx_reg[$clog2(FRAME_DEPTH)-1:0]] <= value;
		end
	end

	// failure pulse: bad length or bad checksum
	always_comb begin
		rx_err = 1'b0;
		rx_err_code = `ERR_CHECKSUM;
		if (byte_ev && !restart) begin
			if (rx_state_reg == RX_LEN_LO &&
				(len_full == `ZERO_LEN || len_full > 16'(FRAME_DEPTH))) begin
				rx_err = 1'b1;
				rx_err_code = `ERR_LENGTH;
			end else if (rx_state_reg == RX_CSUM && 8'(rx_sum_reg + value) != `CSUM_GOOD) begin
				rx_err = 1'b1;
			end
		end
	end

	// ============================================================
	// data output stage toward the packet side
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rf_valid_reg <= 1'b0;
			rf_data_reg <= `ZERO_BYTE;
			rf_last_reg <= 1'b0;
			rd_idx_reg <= `ZERO_LEN;
		end else if (i_ce) begin
			if (!framed && rx_take) begin
				rf_valid_reg <= 1'b1;
				rf_data_reg <= i_rx_data;
				rf_last_reg <= 1'b0;
			end else if (framed && rx_state_reg == RX_RELEASE && rf_load) begin
				rf_valid_reg <= 1'b1;
				rf_data_reg <= frame_mem[rd_idx_reg[$clog2(FRAME_DEPTH)-1:0]];
				rf_last_reg <= (rd_idx_reg == rx_len_reg - 16'h0001);
				rd_idx_reg <= (rd_idx_reg == rx_len_reg - 16'h0001) ? `ZERO_LEN :
					rd_idx_reg + 16'h0001;
			end else if (i_rf_ready) begin
				rf_valid_reg <= 1'b0;
			end
		end
	end

	assign o_rf_valid = rf_valid_reg;
	assign o_rf_data = rf_data_reg;
	assign o_rf_last = rf_last_reg;

	// ============================================================
	// status frame owed; a new failure wins over the pick-up
	assign picking = framed && tx_state_reg == TX_IDLE && err_pend_reg;
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			err_pend_reg <= 1'b0;
			err_code_reg <= `ZERO_BYTE;
		end else if (i_ce) begin
			if (rx_err) begin
				err_pend_reg <= 1'b1;
				err_code_reg <= rx_err_code;
			end else if (picking) begin
				err_pend_reg <= 1'b0;
			end
		end
	end

	// ============================================================
	// transmit byte selection
	always_comb begin
		tx_byte = i_out_data;
		enc_raw = 1'b0;
		enc_up.valid = 1'b0;
		case (tx_state_reg)
			TX_IDLE: enc_up.valid = !framed && i_out_valid;
			TX_START: begin
				enc_up.valid = 1'b1;
				tx_byte = `START_BYTE;
				enc_raw = 1'b1;
			end
			TX_LEN_HI: begin
				enc_up.valid = 1'b1;
				tx_byte = tx_len_reg[15:8];
			end
			TX_LEN_LO: begin
				enc_up.valid = 1'b1;
				tx_byte = tx_len_reg[7:0];
			end
			TX_DATA: begin
				enc_up.valid = from_status_reg || i_out_valid;
				if (from_status_reg) begin
					tx_byte = (tx_cnt_reg == `ZERO_LEN) ? STATUS_TYPE : err_hold_reg;
				end
			end
			TX_CSUM: begin
				enc_up.valid = 1'b1;
				tx_byte = `CSUM_GOOD - tx_sum_reg;
			end
			default: enc_up.valid = 1'b0;
		endcase
	end

	assign enc_up.data = tx_byte;
	assign tx_step = i_ce && enc_up.valid && enc_up.ready;
	assign o_out_ready = (tx_state_reg == TX_IDLE && !framed) ? enc_up.ready :
		(tx_state_reg == TX_DATA && !from_status_reg && enc_up.ready);

	// ============================================================
	// transmit builder
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			tx_state_reg <= TX_IDLE;
			from_status_reg <= 1'b0;
			err_hold_reg <= `ZERO_BYTE;
			tx_len_reg <= `ZERO_LEN;
			tx_cnt_reg <= `ZERO_LEN;
			tx_sum_reg <= `ZERO_BYTE;
		end else if (i_ce) begin
			case (tx_state_reg)
				TX_IDLE: begin
					tx_cnt_reg <= `ZERO_LEN;
					tx_sum_reg <= `ZERO_BYTE;
					if (picking) begin
						from_status_reg <= 1'b1;
						err_hold_reg <= err_code_reg;
						tx_len_reg <= `STATUS_LEN;
						tx_state_reg <= TX_START;
					end else if (framed && i_out_valid) begin
						from_status_reg <= 1'b0;
						tx_len_reg <= i_out_len;
						tx_state_reg <= TX_START;
					end
				end
				TX_START: if (tx_step) tx_state_reg <= TX_LEN_HI;
				TX_LEN_HI: if (tx_step) tx_state_reg <= TX_LEN_LO;
				TX_LEN_LO: begin
					if (tx_step) begin
						tx_state_reg <= (tx_len_reg == `ZERO_LEN) ? TX_CSUM : TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_step) begin
						tx_sum_reg <= tx_sum_reg + tx_byte;
						tx_cnt_reg <= tx_cnt_reg + 16'h0001;
						if (tx_cnt_reg == tx_len_reg - 16'h0001) begin
							tx_state_reg <= TX_CSUM;
						end
					end
				end
				TX_CSUM: if (tx_step) tx_state_reg <= TX_IDLE;
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// ============================================================
	// escaping and buffering toward the host
	escape_encoder u_enc (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_esc_on(esc_on),
		.i_raw(enc_raw),
		.up(enc_up.snk),
		.dn(enc_dn.src)
	);

	byte_fifo2 #(.WIDTH(8), .DEPTH(2)) u_buf (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.wr(enc_dn.snk),
		.rd(fifo_out.src)
	);

	assign o_tx_valid = fifo_out.valid;
	assign o_tx_data = fifo_out.data;
	assign fifo_out.ready = i_tx_ready;
endmodule // serial_api_frame_codec

// ### dv/serial_api_frame_codec_monitor.sv
// Purpose: port checker for the serial frame codec
// Assumes: bound to every codec instance, one clock, synchronous reset
// Notes: only the codec's own ports are watched
module serial_api_frame_codec_checker (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire frame_codec_pkg::api_mode_type i_api_mode_select,
	input wire logic i_host_is_uart,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic o_rx_ready,
	input wire logic o_rf_valid,
	input wire logic [7:0] o_rf_data,
	input wire logic o_rf_last,
	input wire logic i_rf_ready,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic i_tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	import frame_codec_pkg::*;
	// ============================================================
	// helper terms
	logic esc_mode; // escaped framing in force
	logic thru_mode; // transparent operation in force
	logic esc_pend_reg; // escape byte left, its partner byte is next
	assign esc_mode = (i_api_mode_select == MODE_API_ESC) && i_host_is_uart;
	assign thru_mode = (i_api_mode_select == MODE_TRANSPARENT) ||
		(i_api_mode_select == MODE_UNUSED);
	// remember an escape byte taken by the host
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			esc_pend_reg <= 1'b0;
		end else if (i_ce && o_tx_valid && i_tx_ready) begin
			esc_pend_reg <= esc_mode && (o_tx_data == 8'h7D) && !esc_pend_reg;
		end
	end
	// ============================================================
	// assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence rx_take;
		i_ce && i_rx_valid && o_rx_ready;
	endsequence
	a_reset_leaves_idle: assert property ($rose(i_reset_n) |->
		!o_rf_valid && !o_tx_valid && o_rx_ready) else $error("outputs busy after reset");
	a_rf_word_holds: assert property (o_rf_valid && !i_rf_ready && i_ce |=>
		o_rf_valid && $stable(o_rf_data) && $stable(o_rf_last)) else $error("rf byte dropped");
	a_tx_word_holds: assert property (o_tx_valid && !i_tx_ready && i_ce |=>
		o_tx_valid && $stable(o_tx_data)) else $error("tx byte dropped");
	a_thru_byte_pass: assert property (rx_take ##0 thru_mode |=>
		o_rf_valid && !o_rf_last && o_rf_data == $past(i_rx_data)) else $error("byte altered");
	a_thru_ready_rule: assert property (thru_mode |->
		o_rx_ready == (!o_rf_valid || i_rf_ready)) else $error("transparent ready wrong");
	a_last_then_gap: assert property (i_ce && o_rf_valid && o_rf_last && i_rf_ready |=>
		!o_rf_valid) else $error("byte after frame end");
	a_escape_pair_value: assert property (esc_pend_reg && o_tx_valid |->
		o_tx_data inside {8'h5E, 8'h5D, 8'h31, 8'h33}) else $error("bad escaped byte");
	a_no_flow_bytes: assert property (esc_mode && o_tx_valid |->
		o_tx_data != 8'h11 && o_tx_data != 8'h13) else $error("flow byte unescaped");
endmodule // serial_api_frame_codec_checker

bind serial_api_frame_codec serial_api_frame_codec_checker chk (.i_mclk(i_mclk),
	.i_reset_n(i_reset_n), .i_ce(i_ce), .i_api_mode_select(i_api_mode_select),
	.i_host_is_uart(i_host_is_uart), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
	.o_rx_ready(o_rx_ready), .o_rf_valid(o_rf_valid), .o_rf_data(o_rf_data),
	.o_rf_last(o_rf_last), .i_rf_ready(i_rf_ready), .o_tx_valid(o_tx_valid),
	.o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready));

// ### dv/host_serial_model.sv
// Purpose: host processor taking bytes from the codec's serial output
// Assumes: ready changes on the falling edge only
// Notes: slow mode stalls every other cycle so the buffer fills
module host_serial_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$]; // bytes taken from the line, in order
	// ready pattern, toggling while slow; one process drives it
	initial begin
		o_tx_ready = 1'b1;
		forever @(negedge i_mclk) o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
	end
	// a byte moves when valid and ready meet at the rising edge
	always @(posedge i_mclk) begin
		if (i_reset_n && i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
	end
endmodule // host_serial_model

// ### dv/serial_api_frame_codec_test.sv
// Purpose: self-checking bench for the serial frame codec
// Assumes: host model captures the serial output
// Notes: inputs change on the falling edge
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("mismatch %0t: got %h want %h", $time, a, b); end end
module serial_api_frame_codec_test;
	timeunit 1ns;
	timeprecision 1ns;
	import frame_codec_pkg::*;
	typedef logic [7:0] byte_q_type[$];
	localparam logic [7:0] ST = 8'hC5; // status frame type, arbitrary
	logic i_mclk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, i_host_is_uart = 1'b1;
	logic i_rx_valid = 1'b0, i_rf_ready = 1'b1, i_out_valid = 1'b0, slow = 1'b0;
	logic [7:0] i_rx_data = 8'h00, i_out_data = 8'h00;
	logic [15:0] i_out_len = 16'h0000;
	api_mode_type i_api_mode_select = MODE_TRANSPARENT;
	logic o_rx_ready, o_rf_valid, o_rf_last, o_out_ready, o_tx_valid, i_tx_ready;
	logic [7:0] o_rf_data, o_tx_data;
	logic [8:0] rfq[$]; // {last, data} seen toward the radio
	int error_cnt = 0, checks = 0;
	always #50 i_mclk = ~i_mclk;
	serial_api_frame_codec #(.STATUS_TYPE(ST)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_ce(i_ce), .i_api_mode_select(i_api_mode_select), .i_host_is_uart(i_host_is_uart),
		.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
		.o_rf_valid(o_rf_valid), .o_rf_data(o_rf_data), .o_rf_last(o_rf_last),
		.i_rf_ready(i_rf_ready), .i_out_valid(i_out_valid), .i_out_data(i_out_data),
		.i_out_len(i_out_len), .o_out_ready(o_out_ready), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready));
	host_serial_model host (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_slow(slow),
		.i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
	// radio side capture
	always @(posedge i_mclk) begin
		if (i_reset_n && i_ce && o_rf_valid && i_rf_ready) rfq.push_back({o_rf_last, o_rf_data});
	end
	// ============================================================
	// shared tasks
	task report_and_stop;
		if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task timed_out;
		error_cnt++;
		$display("mismatch %0t: wait ran out", $time);
		report_and_stop();
	endtask
	// expected line bytes of one frame
	function automatic byte_q_type frame(bit esc, byte_q_type d);
		byte_q_type raw, q;
		logic [7:0] s;
		s = 8'h00;
		foreach (d[i]) s += d[i];
		raw = d;
		raw.push_front(8'(d.size()));
		raw.push_front(8'(d.size() >> 8));
		raw.push_back(8'hFF - s);
		q.push_back(8'h7E);
		foreach (raw[i]) begin
			if (esc && raw[i] inside {8'h7E, 8'h7D, 8'h11, 8'h13}) begin
				q.push_back(8'h7D);
				q.push_back(raw[i] ^ 8'h20);
			end else q.push_back(raw[i]);
		end
		return q;
	endfunction
	// host bytes into the serial input, back to back
	task put(byte_q_type q);
		int n;
		foreach (q[i]) begin
			i_rx_valid = 1'b1;
			i_rx_data = q[i];
			n = 0;
			// ready is read at the edge, before the design updates it
			@(posedge i_mclk);
			while (o_rx_ready !== 1'b1) begin
				if (++n > 60) timed_out();
				@(posedge i_mclk);
			end
			@(negedge i_mclk);
		end
		i_rx_valid = 1'b0;
		// one idle edge so a following call never re-raises valid at once
		@(negedge i_mclk);
	endtask
	// device payload toward the host
	task send_out(byte_q_type q);
		int n;
		i_out_len = 16'(q.size());
		foreach (q[i]) begin
			i_out_valid = 1'b1;
			i_out_data = q[i];
			n = 0;
			// ready is read at the edge, before the design updates it
			@(posedge i_mclk);
			while (o_out_ready !== 1'b1) begin
				if (++n > 60) timed_out();
				@(posedge i_mclk);
			end
			@(negedge i_mclk);
		end
		i_out_valid = 1'b0;
	endtask
	task cmp_tx(byte_q_type e);
		int n;
		n = 0;
		while (host.got.size() < e.size()) begin
			if (++n > 400) timed_out();
			@(negedge i_mclk);
		end
		repeat (6) @(negedge i_mclk);
		`CHK(host.got.size(), e.size())
		foreach (e[i]) `CHK(host.got[i], e[i])
		host.got.delete();
	endtask
	task cmp_rf(byte_q_type e, bit fr);
		int n;
		n = 0;
		while (rfq.size() < e.size()) begin
			if (++n > 400) timed_out();
			@(negedge i_mclk);
		end
		repeat (4) @(negedge i_mclk);
		`CHK(rfq.size(), e.size())
		foreach (e[i]) `CHK(rfq[i], {fr && (i == e.size() - 1), e[i]})
		rfq.delete();
	endtask
	// ============================================================
	// scenarios
	task t_transparent;
		i_rf_ready = 1'b0;
		put('{8'h7E});
		i_ce = 1'b0; // frozen: the held byte must not be taken
		i_rf_ready = 1'b1;
		repeat (3) @(negedge i_mclk);
		i_ce = 1'b1;
		put('{8'h7D, 8'h11});
		cmp_rf('{8'h7E, 8'h7D, 8'h11}, 1'b0);
		i_api_mode_select = MODE_UNUSED; // setting 3 acts as transparent
		send_out('{8'h7E, 8'h13});
		cmp_tx('{8'h7E, 8'h13});
	endtask
	task t_api_rx;
		byte_q_type bad;
		i_api_mode_select = MODE_API;
		put('{8'h55, 8'h13});
		put(frame(1'b0, '{8'hAA, 8'h7E, 8'h7D, 8'h11}));
		cmp_rf('{8'hAA, 8'h7E, 8'h7D, 8'h11}, 1'b1);
		bad = frame(1'b0, '{8'h42});
		bad[bad.size() - 1] ^= 8'h01;
		put(bad);
		cmp_tx(frame(1'b0, '{ST, 8'h01}));
		`CHK(rfq.size(), 0)
		put('{8'h7E, 8'h00, 8'h00});
		cmp_tx(frame(1'b0, '{ST, 8'h02}));
	endtask
	task t_esc_rx;
		i_api_mode_select = MODE_API_ESC;
		put('{8'h7E, 8'h00, 8'h05, 8'h41});
		put(frame(1'b1, '{8'h11, 8'h7E, 8'h7D, 8'h13}));
		cmp_rf('{8'h11, 8'h7E, 8'h7D, 8'h13}, 1'b1);
	endtask
	task t_esc_tx;
		slow = 1'b1;
		send_out('{8'h7E, 8'h7D, 8'h11, 8'h13});
		cmp_tx(frame(1'b1, '{8'h7E, 8'h7D, 8'h11, 8'h13}));
		slow = 1'b0;
	endtask
	task t_no_uart;
		i_host_is_uart = 1'b0;
		send_out('{8'h7D, 8'h11});
		cmp_tx(frame(1'b0, '{8'h7D, 8'h11}));
		put(frame(1'b0, '{8'h7D, 8'h13}));
		cmp_rf('{8'h7D, 8'h13}, 1'b1);
		i_host_is_uart = 1'b1;
	endtask
	initial begin
		repeat (3) @(negedge i_mclk);
		i_reset_n = 1'b1;
		t_transparent();
		t_api_rx();
		t_esc_rx();
		t_esc_tx();
		t_no_uart();
		report_and_stop();
	end
endmodule // serial_api_frame_codec_test
